// *** src/cfsr_regs.sv ***
`timescale 1ns/1ps
// ****************************************************
// Charger fault and status register bank
// ****************************************************
// Operation
// - Fault bit 7 reads one after watchdog expiry, zero otherwise.
// - Fault bit 6 set when boost cannot start or continue.
// - Charge fault field: normal, input fault, thermal, safety timer.
// - Fault bit 3 reads one during cell overvoltage.
// - Buck mode thermistor codes: normal, warm, cool, cold, hot.
// - Boost mode thermistor codes limited to normal, cold, hot.
// - Status bit 7 shows input supply attached.
// - Status bit 6 shows input voltage regulation active.
// - Status bit 5 shows input current regulation active.
// - Status bit 3 shows finish timer counting.
// - Status bit 2 shows input overvoltage; bit 4 reserved.
// - Bit 1 suppresses voltage regulation interrupt; resets to zero.
// - Bit 0 suppresses current regulation interrupt; resets to zero.
// - Writing one to ident bit 7 restores defaults, restarts timer.
// - Soft reset bit clears itself once reset completes.
module cfsr_regs #(
    parameter logic [3:0] PART_NUMBER = 4'h5, // Arbitrary value
    parameter logic [1:0] SILICON_REV = 2'h1, // Arbitrary value
    parameter logic [3:0] LOAD_CYCLES = cfsr_pkg::LOAD_CYCLES
) (
    input  wire logic       clock,
    input  wire logic       rstn,
    input  wire logic [7:0] regAddr,
    input  wire logic       regWrEn,
    input  wire logic [7:0] regWrData,
    input  wire logic       regRdEn,
    output logic      [7:0] regRdData,
    output logic            regRdValid,
    input  wire logic       watchdogExpired,
    input  wire logic       boostMode,
    input  wire logic       boostOverload,
    input  wire logic       boostBatteryLow,
    input  wire logic       inputOvervoltageState,
    input  wire logic       inputBelowWindow,
    input  wire logic       thermalShutdown,
    input  wire logic       safetyTimerExpired,
    input  wire logic       cellOvervoltage,
    input  wire logic       thermWarm,
    input  wire logic       thermCool,
    input  wire logic       thermCold,
    input  wire logic       thermHot,
    input  wire logic       inputAttached,
    input  wire logic       inputVoltageRegulation,
    input  wire logic       inputCurrentRegulation,
    input  wire logic       finishTimerRunning,
    output logic            voltageRegulationIrqSuppress,
    output logic            currentRegulationIrqSuppress,
    output logic            voltageRegulationIrqPulse,
    output logic            currentRegulationIrqPulse,
    output logic            registerDefaultsLoad,
    output logic            safetyTimerRestart
);

    // ****************************************************
    // Input synchronisation
    // ****************************************************
    logic [cfsr_pkg::SYNC_W-1:0] rawVector;
    logic [cfsr_pkg::SYNC_W-1:0] syncVector;

    logic sWatchdog;
    logic sBoostMode;
    logic sBoostOverload;
    logic sBoostBatteryLow;
    logic sInputOvervoltage;
    logic sInputBelowWindow;
    logic sThermalShutdown;
    logic sSafetyTimer;
    logic sCellOvervoltage;
    logic sThermWarm;
    logic sThermCool;
    logic sThermCold;
    logic sThermHot;
    logic sInputAttached;
    logic sVoltageRegulation;
    logic sCurrentRegulation;
    logic sFinishTimer;

    assign rawVector = {watchdogExpired, boostMode, boostOverload,
                        boostBatteryLow, inputOvervoltageState,
                        inputBelowWindow, thermalShutdown,
                        safetyTimerExpired, cellOvervoltage,
                        thermWarm, thermCool, thermCold, thermHot,
                        inputAttached, inputVoltageRegulation,
                        inputCurrentRegulation, finishTimerRunning};

    assign {sWatchdog, sBoostMode, sBoostOverload,
            sBoostBatteryLow, sInputOvervoltage,
            sInputBelowWindow, sThermalShutdown,
            sSafetyTimer, sCellOvervoltage,
            sThermWarm, sThermCool, sThermCold, sThermHot,
            sInputAttached, sVoltageRegulation,
            sCurrentRegulation, sFinishTimer} = syncVector;

    cfsr_sync #(
        .WIDTH    (cfsr_pkg::SYNC_W)
    ) uSync (
        .clock    (clock),
        .rstn     (rstn),
        .rawIn    (rawVector),
        .cleanOut (syncVector)
    );

    // ****************************************************
    // Fault encoding
    // ****************************************************
    logic       boostFault;
    logic [1:0] chargingErrorCode;
    logic [2:0] thermistorZoneCode;

    cfsr_fault_encode uEncode (
        .boostMode             (sBoostMode),
        .boostOverload         (sBoostOverload),
        .boostBatteryLow       (sBoostBatteryLow),
        .inputOvervoltageState (sInputOvervoltage),
        .inputBelowWindow      (sInputBelowWindow),
        .thermalShutdown       (sThermalShutdown),
        .safetyTimerExpired    (sSafetyTimer),
        .thermWarm             (sThermWarm),
        .thermCool             (sThermCool),
        .thermCold             (sThermCold),
        .thermHot              (sThermHot),
        .boostFault            (boostFault),
        .chargingErrorCode     (chargingErrorCode),
        .thermistorZoneCode    (thermistorZoneCode)
    );

    // ****************************************************
    // Address decode
    // ****************************************************
    wire hitFault = (regAddr == cfsr_pkg::ADDR_FAULT);
    wire hitInput = (regAddr == cfsr_pkg::ADDR_INPUT);
    wire hitIdent = (regAddr == cfsr_pkg::ADDR_IDENT);
    wire wrInput  = regWrEn & hitInput;
    wire wrIdent  = regWrEn & hitIdent;
    wire softResetRequest = wrIdent & regWrData[cfsr_pkg::ID_RST_BIT];

    // ****************************************************
    // Soft reset sequencer
    // ****************************************************
    cfsr_pkg::cfsr_rst_state_t rstState_reg;
    cfsr_pkg::cfsr_rst_state_t rstState_next;
    logic [3:0] loadCount_reg;
    logic [3:0] loadCount_next;
    logic       softResetBit_reg;
    logic       softResetBit_next;

    wire loadActive = (rstState_reg == cfsr_pkg::CFSR_LOAD);
    wire loadLast   = loadActive & (loadCount_reg == LOAD_CYCLES - 4'h1);
    wire resetDone  = (rstState_reg == cfsr_pkg::CFSR_DONE);

    always_comb begin
        rstState_next  = rstState_reg;
        loadCount_next = 4'h0;
        case (rstState_reg)
            cfsr_pkg::CFSR_IDLE: begin
                if (softResetBit_reg) begin
                    rstState_next = cfsr_pkg::CFSR_LOAD;
                end
            end
            cfsr_pkg::CFSR_LOAD: begin
                loadCount_next = loadCount_reg + 4'h1;
                if (loadLast) begin
                    rstState_next = cfsr_pkg::CFSR_DONE;
                end
            end
            cfsr_pkg::CFSR_DONE: begin
                rstState_next = cfsr_pkg::CFSR_IDLE;
            end
            default: begin
                rstState_next = cfsr_pkg::CFSR_IDLE;
            end
        endcase
    end

    // A new request in the finishing cycle keeps the bit set
    assign softResetBit_next = softResetRequest ? 1'h1 :
                               resetDone ? cfsr_pkg::SOFT_RST_RESET :
                               softResetBit_reg;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rstState_reg     <= cfsr_pkg::CFSR_IDLE;
            loadCount_reg    <= 4'h0;
            softResetBit_reg <= cfsr_pkg::SOFT_RST_RESET;
        end else begin
            rstState_reg     <= rstState_next;
            loadCount_reg    <= loadCount_next;
            softResetBit_reg <= softResetBit_next;
        end
    end

    // Rest of the charger reloads its settings on this level
    assign registerDefaultsLoad = loadActive;
    assign safetyTimerRestart   = loadActive;

    // ****************************************************
    // Interrupt suppress bits
    // ****************************************************
    logic vMask_reg;
    logic vMask_next;
    logic iMask_reg;
    logic iMask_next;

    // Defaults win over a host write landing during reload
    assign vMask_next = loadActive ? cfsr_pkg::MASK_RESET :
        wrInput ? regWrData[cfsr_pkg::IN_VMASK_BIT] :
        vMask_reg;
    assign iMask_next = loadActive ? cfsr_pkg::MASK_RESET :
        wrInput ? regWrData[cfsr_pkg::IN_IMASK_BIT] :
        iMask_reg;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            vMask_reg <= cfsr_pkg::MASK_RESET;
            iMask_reg <= cfsr_pkg::MASK_RESET;
        end else begin
            vMask_reg <= vMask_next;
            iMask_reg <= iMask_next;
        end
    end

    assign voltageRegulationIrqSuppress = vMask_reg;
    assign currentRegulationIrqSuppress = iMask_reg;

    // ****************************************************
    // Regulation entry events
    // ****************************************************
    logic vRegPrev_reg;
    logic iRegPrev_reg;
    logic vPulse_reg;
    logic iPulse_reg;

    wire vEntry = sVoltageRegulation & ~vRegPrev_reg;
    wire iEntry = sCurrentRegulation & ~iRegPrev_reg;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            vRegPrev_reg <= 1'h0;
            iRegPrev_reg <= 1'h0;
            vPulse_reg   <= 1'h0;
            iPulse_reg   <= 1'h0;
        end else begin
            vRegPrev_reg <= sVoltageRegulation;
            iRegPrev_reg <= sCurrentRegulation;
            vPulse_reg   <= vEntry & ~vMask_reg;
            iPulse_reg   <= iEntry & ~iMask_reg;
        end
    end

    assign voltageRegulationIrqPulse = vPulse_reg;
    assign currentRegulationIrqPulse = iPulse_reg;

    // ****************************************************
    // Read words
    // ****************************************************
    logic [7:0] faultWord;
    logic [7:0] inputWord;
    logic [7:0] identWord;

    always_comb begin
        faultWord = 8'h00;
        faultWord[cfsr_pkg::FLT_WDOG_BIT] = sWatchdog;
        faultWord[cfsr_pkg::FLT_BOOST_BIT] = boostFault;
        faultWord[cfsr_pkg::FLT_CHG_LSB +: 2] =
            chargingErrorCode;
        faultWord[cfsr_pkg::FLT_CELL_OV_BIT] =
            sCellOvervoltage;
        faultWord[cfsr_pkg::FLT_THERM_LSB +: 3] =
            thermistorZoneCode;
    end

    always_comb begin
        inputWord = 8'h00;
        inputWord[cfsr_pkg::IN_ATTACH_BIT] = sInputAttached;
        inputWord[cfsr_pkg::IN_VREG_BIT] = sVoltageRegulation;
        inputWord[cfsr_pkg::IN_IREG_BIT] = sCurrentRegulation;
        inputWord[cfsr_pkg::IN_RSVD_BIT] =
            cfsr_pkg::RESERVED_VALUE;
        inputWord[cfsr_pkg::IN_FINISH_BIT] = sFinishTimer;
        inputWord[cfsr_pkg::IN_OV_BIT] = sInputOvervoltage;
        inputWord[cfsr_pkg::IN_VMASK_BIT] = vMask_reg;
        inputWord[cfsr_pkg::IN_IMASK_BIT] = iMask_reg;
    end

    always_comb begin
        identWord = 8'h00;
        identWord[cfsr_pkg::ID_RST_BIT] = softResetBit_reg;
        identWord[cfsr_pkg::ID_PN_LSB +: 4] = PART_NUMBER;
        identWord[cfsr_pkg::ID_RSVD_BIT] =
            cfsr_pkg::RESERVED_VALUE;
        identWord[cfsr_pkg::ID_REV_LSB +: 2] = SILICON_REV;
    end

    wire [7:0] readSelect = hitFault ? faultWord :
                            hitInput ? inputWord :
                            hitIdent ? identWord :
                            cfsr_pkg::UNMAPPED_DATA;

    // ****************************************************
    // Read port
    // ****************************************************
    // Data is captured once per read, so a multi-byte read
    // by the serial side sees each register at its own instant.
    logic [7:0] rdData_reg;
    logic       rdValid_reg;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rdData_reg  <= 8'h00;
            rdValid_reg <= 1'h0;
        end else begin
            rdValid_reg <= regRdEn;
            if (regRdEn) begin
                rdData_reg <= readSelect;
            end
        end
    end

    assign regRdData  = rdData_reg;
    assign regRdValid = rdValid_reg;

endmodule

// *** pkg/cfsr_pkg.sv ***
package cfsr_pkg;

    // ****************************************************
    // Register map
    // ****************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] ADDR_FAULT = 8'h09;
    localparam logic [7:0] ADDR_INPUT = 8'h0a;
    localparam logic [7:0] ADDR_IDENT = 8'h0b;
    localparam logic [7:0] UNMAPPED_DATA = 8'h00;
    localparam logic RESERVED_VALUE = 1'h0;

    // ****************************************************
    // Fault register fields
    // ****************************************************
    localparam int FLT_WDOG_BIT = 7;
    localparam int FLT_BOOST_BIT = 6;
    localparam int FLT_CHG_LSB = 4;
    localparam int FLT_CELL_OV_BIT = 3;
    localparam int FLT_THERM_LSB = 0;
    localparam logic [1:0] CHG_NORMAL = 2'h0;
    localparam logic [1:0] CHG_INPUT = 2'h1;
    localparam logic [1:0] CHG_THERMAL = 2'h2;
    localparam logic [1:0] CHG_TIMER = 2'h3;
    localparam logic [2:0] TZ_NORMAL = 3'h0;
    localparam logic [2:0] TZ_WARM = 3'h2;
    localparam logic [2:0] TZ_COOL = 3'h3;
    localparam logic [2:0] TZ_COLD = 3'h5;
    localparam logic [2:0] TZ_HOT = 3'h6;

    // ****************************************************
    // Input status and mask register fields
    // ****************************************************
    localparam int IN_ATTACH_BIT = 7;
    localparam int IN_VREG_BIT = 6;
    localparam int IN_IREG_BIT = 5;
    localparam int IN_RSVD_BIT = 4;
    localparam int IN_FINISH_BIT = 3;
    localparam int IN_OV_BIT = 2;
    localparam int IN_VMASK_BIT = 1;
    localparam int IN_IMASK_BIT = 0;
    localparam logic MASK_RESET = 1'h0;

    // ****************************************************
    // Identification register fields
    // ****************************************************
    localparam int ID_RST_BIT = 7;
    localparam int ID_PN_LSB = 3;
    localparam int ID_RSVD_BIT = 2;
    localparam int ID_REV_LSB = 0;
    localparam logic SOFT_RST_RESET = 1'h0;

    // ****************************************************
    // Inputs and timing
    // ****************************************************
    localparam int SYNC_W = 17;
    localparam logic [3:0] LOAD_CYCLES = 4'h2;

    typedef enum logic [2:0] {
        CFSR_IDLE = 3'b001,
        CFSR_LOAD = 3'b010,
        CFSR_DONE = 3'b100
    } cfsr_rst_state_t;

endpackage

// *** src/cfsr_sync.sv ***
`timescale 1ns/1ps
module cfsr_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] rawIn,
    output logic      [WIDTH-1:0] cleanOut
);

    // ****************************************************
    // Three flops per bit plus an output flop, change taken when last two agree
    // ****************************************************
    // Analog flags may chatter near thresholds; the agree
    // check costs one cycle but hides single-cycle glitches.
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : gBit
            logic stage1_reg;
            logic stage2_reg;
            logic stage3_reg;
            logic clean_reg;
            always_ff @(posedge clock or negedge rstn) begin
                if (!rstn) begin
                    stage1_reg <= 1'h0;
                    stage2_reg <= 1'h0;
                    stage3_reg <= 1'h0;
                    clean_reg  <= 1'h0;
                end else begin
                    stage1_reg <= rawIn[i];
                    stage2_reg <= stage1_reg;
                    stage3_reg <= stage2_reg;
                    if (stage2_reg == stage3_reg) begin
                        clean_reg <= stage3_reg;
                    end
                end
            end
            assign cleanOut[i] = clean_reg;
        end
    endgenerate

endmodule

// *** src/cfsr_fault_encode.sv ***
`timescale 1ns/1ps
module cfsr_fault_encode (
    input  wire logic       boostMode,
    input  wire logic       boostOverload,
    input  wire logic       boostBatteryLow,
    input  wire logic       inputOvervoltageState,
    input  wire logic       inputBelowWindow,
    input  wire logic       thermalShutdown,
    input  wire logic       safetyTimerExpired,
    input  wire logic       thermWarm,
    input  wire logic       thermCool,
    input  wire logic       thermCold,
    input  wire logic       thermHot,
    output logic            boostFault,
    output logic      [1:0] chargingErrorCode,
    output logic      [2:0] thermistorZoneCode
);

    // ****************************************************
    // Boost and charge fault
    // ****************************************************
    assign boostFault = boostOverload | inputOvervoltageState
                      | boostBatteryLow;

    wire inputFault = inputOvervoltageState | inputBelowWindow;

    // Thermal shutdown outranks timer, timer outranks input
    assign chargingErrorCode =
        thermalShutdown    ? cfsr_pkg::CHG_THERMAL :
        safetyTimerExpired ? cfsr_pkg::CHG_TIMER :
        inputFault         ? cfsr_pkg::CHG_INPUT :
                             cfsr_pkg::CHG_NORMAL;

    // ****************************************************
    // Thermistor zone
    // ****************************************************
    wire [2:0] buckZone =
        thermHot  ? cfsr_pkg::TZ_HOT :
        thermCold ? cfsr_pkg::TZ_COLD :
        thermWarm ? cfsr_pkg::TZ_WARM :
        thermCool ? cfsr_pkg::TZ_COOL :
                    cfsr_pkg::TZ_NORMAL;

    // Warm and cool have no meaning while boosting
    wire [2:0] boostZone =
        thermHot  ? cfsr_pkg::TZ_HOT :
        thermCold ? cfsr_pkg::TZ_COLD :
                    cfsr_pkg::TZ_NORMAL;

    assign thermistorZoneCode = boostMode ? boostZone : buckZone;

endmodule

// *** sim/cfsr_regs_asserts.sv ***
`timescale 1ns/1ps
// ****************************************************
// Register port and reload checks
// ****************************************************
module cfsr_regs_asserts #(
    parameter logic [3:0] LOAD_CYCLES = 4'h2
) (
    input wire logic       clock,
    input wire logic       rstn,
    input wire logic [7:0] regAddr,
    input wire logic       regWrEn,
    input wire logic [7:0] regWrData,
    input wire logic       regRdEn,
    input wire logic [7:0] regRdData,
    input wire logic       regRdValid,
    input wire logic       voltageRegulationIrqSuppress,
    input wire logic       currentRegulationIrqSuppress,
    input wire logic       voltageRegulationIrqPulse,
    input wire logic       currentRegulationIrqPulse,
    input wire logic       registerDefaultsLoad,
    input wire logic       safetyTimerRestart
);
    logic [3:0] loadRun_reg;
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    // Length of the current reload burst
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            loadRun_reg <= 4'h0;
        end else begin
            loadRun_reg <= registerDefaultsLoad ? loadRun_reg + 4'h1 : 4'h0;
        end
    end
    a_read_answer: assert property (regRdEn |=> regRdValid)
        else $error("read not answered");
    a_valid_pulse: assert property (!regRdEn |=> !regRdValid)
        else $error("read valid without read");
    a_unmapped_zero: assert property (regRdEn && (regAddr < 8'h09 ||
        regAddr > 8'h0b) |=> regRdData == 8'h00)
        else $error("unmapped read not zero");
    a_reserved_zero: assert property (regRdEn && (regAddr == 8'h0a)
        |=> regRdData[4] == 1'b0)
        else $error("reserved bit set");
    a_vmask_write: assert property (regWrEn && regAddr == 8'h0a &&
        !registerDefaultsLoad |=> voltageRegulationIrqSuppress ==
        $past(regWrData[1]))
        else $error("voltage mask not written");
    a_imask_write: assert property (regWrEn && regAddr == 8'h0a &&
        !registerDefaultsLoad |=> currentRegulationIrqSuppress ==
        $past(regWrData[0]))
        else $error("current mask not written");
    a_mask_defaults: assert property (registerDefaultsLoad |=>
        !voltageRegulationIrqSuppress && !currentRegulationIrqSuppress)
        else $error("masks not restored");
    a_reload_start: assert property (regWrEn && regAddr == 8'h0b &&
        regWrData[7] && !registerDefaultsLoad |-> ##[1:3]
        registerDefaultsLoad)
        else $error("reload did not start");
    a_load_length: assert property ($fell(registerDefaultsLoad) |->
        loadRun_reg == LOAD_CYCLES)
        else $error("reload length wrong");
    a_timer_restart: assert property (1'b1 |->
        safetyTimerRestart == registerDefaultsLoad)
        else $error("timer restart mismatch");
    a_vpulse_masked: assert property (
        $past(voltageRegulationIrqSuppress) &&
        voltageRegulationIrqSuppress |-> !voltageRegulationIrqPulse)
        else $error("masked pulse seen");
    a_ipulse_masked: assert property (
        $past(currentRegulationIrqSuppress) &&
        currentRegulationIrqSuppress |-> !currentRegulationIrqPulse)
        else $error("masked current pulse seen");
    a_pulse_single: assert property (voltageRegulationIrqPulse |=>
        !voltageRegulationIrqPulse)
        else $error("pulse too long");
endmodule
bind cfsr_regs cfsr_regs_asserts #(.LOAD_CYCLES(LOAD_CYCLES)) chk_i (
    .clock, .rstn, .regAddr, .regWrEn, .regWrData, .regRdEn, .regRdData,
    .regRdValid, .voltageRegulationIrqSuppress,
    .currentRegulationIrqSuppress, .voltageRegulationIrqPulse,
    .currentRegulationIrqPulse, .registerDefaultsLoad, .safetyTimerRestart
);

// *** sim/cfsr_host_model.sv ***
`timescale 1ns/1ps
// ****************************************************
// Host side of the register port
// ****************************************************
module cfsr_host_model (
    input  wire logic       clock,
    output logic      [7:0] regAddr,
    output logic            regWrEn,
    output logic      [7:0] regWrData,
    output logic            regRdEn,
    input  wire logic [7:0] regRdData,
    input  wire logic       regRdValid
);
    initial begin
        regAddr = 8'h00;
        regWrEn = 1'b0;
        regWrData = 8'h00;
        regRdEn = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge clock);
        regWrEn <= 1'b0;
        // Stale data must not look valid
        regWrData <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        int k;
        @(posedge clock);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge clock);
        regRdEn <= 1'b0;
        d = 8'hxx;
        for (k = 0; k < 4; k++) begin
            @(posedge clock);
            if (regRdValid === 1'b1) begin
                d = regRdData;
                break;
            end
        end
    endtask
endmodule

// *** sim/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    localparam logic [3:0] PN = 4'ha;  // Arbitrary value
    localparam logic [1:0] REV = 2'h2; // Arbitrary value
    localparam logic [7:0] ID = {1'b0, PN, 1'b0, REV};
    logic        clock = 1'b0;
    logic        rstn = 1'b0;
    logic [16:0] st = 17'h0;
    logic [7:0]  regAddr, regWrData, regRdData, rv;
    logic        regWrEn, regRdEn, regRdValid, vSup, iSup, vIrq, iIrq;
    logic        loadOn, tmrOn;
    int          errors = 0, total_checks = 0, vCnt = 0, iCnt = 0, n, k;
    // Stimulus vector, address, expected byte
    logic [32:0] tbl [19] = '{
        {17'h00001, 8'h09, 8'h80}, {17'h00004, 8'h09, 8'h40},
        {17'h00008, 8'h09, 8'h40}, {17'h00010, 8'h09, 8'h50},
        {17'h00010, 8'h0a, 8'h04}, {17'h00020, 8'h09, 8'h10},
        {17'h00040, 8'h09, 8'h20}, {17'h00080, 8'h09, 8'h30},
        {17'h000c0, 8'h09, 8'h20}, {17'h00100, 8'h09, 8'h08},
        {17'h00200, 8'h09, 8'h02}, {17'h00400, 8'h09, 8'h03},
        {17'h00800, 8'h09, 8'h05}, {17'h01000, 8'h09, 8'h06},
        {17'h00202, 8'h09, 8'h00}, {17'h01002, 8'h09, 8'h06},
        {17'h02000, 8'h0a, 8'h80}, {17'h08000, 8'h0a, 8'h20},
        {17'h10000, 8'h0a, 8'h08}};
    cfsr_host_model host_i (.clock, .regAddr, .regWrEn, .regWrData,
        .regRdEn, .regRdData, .regRdValid);
    cfsr_regs #(.PART_NUMBER(PN), .SILICON_REV(REV), .LOAD_CYCLES(4'h2))
    cfsr_regs_i (.clock, .rstn, .regAddr, .regWrEn, .regWrData, .regRdEn,
        .regRdData, .regRdValid, .watchdogExpired(st[0]),
        .boostMode(st[1]), .boostOverload(st[2]), .boostBatteryLow(st[3]),
        .inputOvervoltageState(st[4]), .inputBelowWindow(st[5]),
        .thermalShutdown(st[6]), .safetyTimerExpired(st[7]),
        .cellOvervoltage(st[8]), .thermWarm(st[9]), .thermCool(st[10]),
        .thermCold(st[11]), .thermHot(st[12]), .inputAttached(st[13]),
        .inputVoltageRegulation(st[14]), .inputCurrentRegulation(st[15]),
        .finishTimerRunning(st[16]), .voltageRegulationIrqSuppress(vSup),
        .currentRegulationIrqSuppress(iSup),
        .voltageRegulationIrqPulse(vIrq), .currentRegulationIrqPulse(iIrq),
        .registerDefaultsLoad(loadOn), .safetyTimerRestart(tmrOn));
    initial begin
        forever #4 clock = ~clock;
    end
    always @(posedge clock) begin
        if (vIrq === 1'b1) vCnt++;
        if (iIrq === 1'b1) iCnt++;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        if (errors == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Status inputs pass a synchronizer, so let them settle
    task automatic apply(input logic [16:0] v);
        @(posedge clock);
        st <= v;
        repeat (8) @(posedge clock);
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        errors++;
        end_sim();
    end
    initial begin
        repeat (6) @(posedge clock);
        rstn <= 1'b1;
        host_i.rd(8'h0a, rv); chk(rv, 8'h00);
        host_i.rd(8'h0b, rv); chk(rv, ID);
        for (k = 0; k < 19; k++) begin
            apply(tbl[k][32:16]);
            host_i.rd(tbl[k][15:8], rv);
            chk(rv, tbl[k][7:0]);
        end
        host_i.wr(8'h0a, 8'hff);
        apply(17'h0);
        vCnt = 0;
        iCnt = 0;
        apply(17'h0c000);
        chk(8'(vCnt + iCnt), 8'h00);
        host_i.rd(8'h0a, rv); chk(rv, 8'h63);
        host_i.wr(8'h0a, 8'h00);
        apply(17'h0);
        apply(17'h0c000);
        chk(8'(vCnt), 8'h01);
        chk(8'(iCnt), 8'h01);
        host_i.wr(8'h09, 8'hff);
        host_i.wr(8'h0b, 8'h7f);
        host_i.rd(8'h09, rv); chk(rv, 8'h00);
        host_i.rd(8'h0b, rv); chk(rv, ID);
        host_i.rd(8'h3c, rv); chk(rv, 8'h00);
        host_i.wr(8'h0a, 8'h03);
        host_i.wr(8'h0b, 8'h80);
        n = 0;
        for (k = 0; k < 12; k++) begin
            @(posedge clock);
            if (loadOn === 1'b1 && tmrOn === 1'b1) n++;
        end
        chk(8'(n), 8'h02);
        host_i.rd(8'h0a, rv); chk(rv, 8'h60);
        host_i.rd(8'h0b, rv); chk(rv, ID);
        host_i.wr(8'h0a, 8'h02);
        host_i.rd(8'h0a, rv); chk(rv, 8'h62);
        chk({6'h00, vSup, iSup}, 8'h02);
        @(posedge clock);
        rstn <= 1'b0;
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        repeat (8) @(posedge clock);
        host_i.rd(8'h0a, rv); chk(rv, 8'h60);
        end_sim();
    end
endmodule
